// File: logic/loss_alarm_defines.svh
`ifndef LOSS_ALARM_DEFINES_SVH
`define LOSS_ALARM_DEFINES_SVH

// register byte offsets
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define EVENT_OFFSET 8'h08

// control fields
`define CTRL_STD_BIT 0
`define CTRL_LAC_BIT 1
`define CTRL_LONG_HAUL_BIT 2
`define CTRL_CODE_LSB 3
`define CTRL_CODE_MSB 7
`define CTRL_SYS_AIS_BIT 8
`define CTRL_LINE_AIS_BIT 9
`define CTRL_CDR_BIT 10
`define CTRL_IRQ_EN_BIT 11
`define CTRL_LOOP_LSB 12
`define CTRL_LOOP_MSB 13
`define CTRL_WIDTH 14
`define CTRL_RESET 14'h04a8

// status and event fields
`define STATUS_LOSS_BIT 0
`define STATUS_ALARM_BIT 1
`define STATUS_IRQ_BIT 2
`define EVENT_LOSS_BIT 0

// thresholds
`define SHORT_DECLARE_MV 10'd800
`define SHORT_HYST_MV 10'd200
`define LONG_HYST_DB 10'd4
`define CODE_SAT 5'd21
`define DB_OFFSET 10'd4
`define DB_FLOOR 10'd48

// loss counts in bit intervals
`define T1_DECLARE_SHORT 12'd175
`define T1_DECLARE_LONG 12'd1544
`define E1_DECLARE_SHORT 12'd32
`define E1_DECLARE_LONG 12'd2048
`define T1_WINDOW 8'd128
`define E1_WINDOW 8'd32
`define T1_ZERO_LIMIT 7'd100
`define E1_ZERO_LIMIT 7'd16
`define MARK_DENSITY_SHIFT 3

// alarm block sizes and zero thresholds
`define E1_BLOCK_BITS 14'd512
`define T1_BLOCK_BITS 14'd8192
`define E1_MIN_ZEROS 4'd3
`define T1_MIN_ZEROS 4'd9

`endif

// File: logic/loss_alarm_pkg.sv
package loss_alarm_pkg;
    typedef enum logic {watch_loss, in_loss} loss_state_t;
    typedef enum logic [1:0] {pin_pos, pin_neg, pin_below, pin_above} pin_idx_t;
endpackage

// File: logic/zero_block_counter.sv
`timescale 1ns/10ps
`default_nettype none
`include "loss_alarm_defines.svh"

module zero_block_counter (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic clear,
    input wire logic bit_tick,
    input wire logic bit_zero,
    input wire logic [13:0] block_bits,
    input wire logic [3:0] min_zeros,
    output logic block_done,
    output logic block_low
);
    logic [13:0] bit_cnt_q;
    logic [3:0] zero_cnt_q;
    logic [3:0] zero_cnt_d;
    logic last_bit;

    // zero count saturates at the threshold
    assign zero_cnt_d = (bit_zero && zero_cnt_q < min_zeros) ? zero_cnt_q + 4'h1 : zero_cnt_q;
    assign last_bit = bit_tick && (bit_cnt_q == block_bits - 14'h0001);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_q <= 14'h0000;
            zero_cnt_q <= 4'h0;
        end else if (clk_en) begin
            if (clear) begin
                bit_cnt_q <= 14'h0000;
                zero_cnt_q <= 4'h0;
            end else if (last_bit) begin
                bit_cnt_q <= 14'h0000;
                zero_cnt_q <= 4'h0;
            end else if (bit_tick) begin
                bit_cnt_q <= bit_cnt_q + 14'h0001;
                zero_cnt_q <= zero_cnt_d;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            block_done <= 1'b0;
            block_low <= 1'b0;
        end else if (clk_en) begin
            block_done <= last_bit && !clear;
            if (last_bit) begin
                block_low <= zero_cnt_d < min_zeros;
            end
        end
    end
endmodule
`default_nettype wire

// File: logic/line_loss_and_alarm_detector.sv
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "loss_alarm_defines.svh"

// Functional notes
// - declare loss after N intervals below Q; loss pin high, interrupt unless masked.
// - clear loss when above P with 12.5% marks over M intervals from a pulse.
// - short haul declares below 800 mVpp, clears above Q plus 200 mVpp.
// - long haul Q from five-bit code, clear at Q plus 4 dB.
// - code resets to 10101 (-46 dB); -4 dB minus 2 dB per step; 10110+ is -48.
// - T1/J1 declare count is 175, or 1544 with criteria select set.
// - E1 declare count is 32, or 2048 with criteria select set.
// - T1/J1 clear window 128 intervals, 12.5% marks, under 100 zeros in a row.
// - E1 clear window 32 intervals, 12.5% marks, under 16 zeros in a row.
// - criteria set chosen by criteria select and standard select together.
// - loss with system insert set: rails all ones, clock out from master clock.
// - loss with line insert set: line pair sends all ones on master clock.
// - loss indicator works in every loopback mode, never suppressed.
// - alarm detection only with clock recovery enabled; result in status bit.
// - E1 select 0: two blocks of 512 under 3 zeros declare, two with 3+ clear.
// - E1 select 1: one 512-bit block with 3 or more zeros clears.
// - T1/J1: 8192-bit block under 9 zeros declares, 9 or more clears.
// - criteria select resets to 0.
module line_loss_and_alarm_detector (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic receive_line_positive,
    input wire logic receive_line_negative,
    input wire logic below_declare_level,
    input wire logic above_clear_level,
    input wire logic recovered_clock_pin,
    input wire logic master_clock_pin,
    input wire logic tx_system_positive,
    input wire logic tx_system_negative,
    output logic receive_data_positive_rail,
    output logic receive_data_negative_rail,
    output logic receive_clock_out,
    output logic transmit_line_positive,
    output logic transmit_line_negative,
    output logic loss_indicator_pin,
    output logic loss_irq,
    output logic [9:0] declare_threshold,
    output logic [9:0] clear_threshold,
    output logic threshold_in_db
);
    import loss_alarm_pkg::*;

    localparam int PINS = 6;
    localparam int REC_CLK = 4;
    localparam int MST_CLK = 5;

    // reset release
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // pin synchronisers
    logic [PINS-1:0] pin_raw;
    logic [PINS-1:0] sync1_q;
    logic [PINS-1:0] sync2_q;
    logic [PINS-1:0] sync3_q;
    logic [PINS-1:0] pin_lvl_q;
    logic [PINS-1:0] pin_rise;

    assign pin_raw = {master_clock_pin, recovered_clock_pin, above_clear_level,
                      below_declare_level, receive_line_negative, receive_line_positive};

    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_sync
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_q[g] <= 1'b0;
                    sync2_q[g] <= 1'b0;
                    sync3_q[g] <= 1'b0;
                    pin_lvl_q[g] <= 1'b0;
                end else if (clk_en) begin
                    sync1_q[g] <= pin_raw[g];
                    sync2_q[g] <= sync1_q[g];
                    sync3_q[g] <= sync2_q[g];
                    if (sync2_q[g] == sync3_q[g]) begin
                        pin_lvl_q[g] <= sync3_q[g];
                    end
                end
            end
            assign pin_rise[g] = sync2_q[g] && sync3_q[g] && !pin_lvl_q[g];
        end
    endgenerate

    logic bit_tick;
    logic mclk_tick;
    logic mark;
    logic below_q;
    logic above_p;

    assign bit_tick = clk_en && pin_rise[REC_CLK];
    assign mclk_tick = clk_en && pin_rise[MST_CLK];
    assign mark = pin_lvl_q[pin_pos] || pin_lvl_q[pin_neg];
    assign below_q = pin_lvl_q[pin_below];
    assign above_p = pin_lvl_q[pin_above];

    // control register
    logic [`CTRL_WIDTH-1:0] ctrl_q;
    logic t1_mode;
    logic loss_criteria_select;
    logic long_haul;
    logic [4:0] code;
    logic sys_ais_en;
    logic line_ais_en;
    logic cdr_en;
    logic irq_en;

    assign t1_mode = ctrl_q[`CTRL_STD_BIT];
    assign loss_criteria_select = ctrl_q[`CTRL_LAC_BIT];
    assign long_haul = ctrl_q[`CTRL_LONG_HAUL_BIT];
    assign code = ctrl_q[`CTRL_CODE_MSB:`CTRL_CODE_LSB];
    assign sys_ais_en = ctrl_q[`CTRL_SYS_AIS_BIT];
    assign line_ais_en = ctrl_q[`CTRL_LINE_AIS_BIT];
    assign cdr_en = ctrl_q[`CTRL_CDR_BIT];
    assign irq_en = ctrl_q[`CTRL_IRQ_EN_BIT];

    // criteria set from standard and criteria select
    logic [11:0] declare_n;
    logic [7:0] window_m;
    logic [6:0] zero_limit;
    logic [7:0] min_marks;

    always_comb begin
        unique case ({t1_mode, loss_criteria_select})
            2'b10: declare_n = `T1_DECLARE_SHORT;
            2'b11: declare_n = `T1_DECLARE_LONG;
            2'b00: declare_n = `E1_DECLARE_SHORT;
            2'b01: declare_n = `E1_DECLARE_LONG;
        endcase
    end

    assign window_m = t1_mode ? `T1_WINDOW : `E1_WINDOW;
    assign zero_limit = t1_mode ? `T1_ZERO_LIMIT : `E1_ZERO_LIMIT;
    assign min_marks = window_m >> `MARK_DENSITY_SHIFT;

    // threshold outputs to the analog comparators
    logic [9:0] code_db;

    assign code_db = (code > `CODE_SAT) ? `DB_FLOOR : `DB_OFFSET + {4'h0, code, 1'b0};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            declare_threshold <= 10'h000;
            clear_threshold <= 10'h000;
            threshold_in_db <= 1'b0;
        end else if (clk_en) begin
            threshold_in_db <= long_haul;
            if (long_haul) begin
                declare_threshold <= code_db;
                clear_threshold <= code_db - `LONG_HYST_DB;
            end else begin
                declare_threshold <= `SHORT_DECLARE_MV;
                clear_threshold <= `SHORT_DECLARE_MV + `SHORT_HYST_MV;
            end
        end
    end

    // loss declare run counter
    loss_state_t loss_q;
    logic [11:0] low_run_q;
    logic declare_hit;

    assign declare_hit = bit_tick && loss_q == watch_loss && below_q && !mark
                         && (low_run_q + 12'h001 >= declare_n);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_run_q <= 12'h000;
        end else if (bit_tick) begin
            if (loss_q == watch_loss && below_q && !mark && !declare_hit) begin
                low_run_q <= low_run_q + 12'h001;
            end else begin
                low_run_q <= 12'h000;
            end
        end
    end

    // clear window, opened by a received pulse
    logic win_act_q;
    logic [7:0] win_cnt_q;
    logic [7:0] mark_cnt_q;
    logic [6:0] zrun_q;
    logic win_ok_q;
    logic [7:0] mark_cnt_d;
    logic [6:0] zrun_d;
    logic win_ok_d;
    logic win_end;
    logic clear_hit;

    assign mark_cnt_d = mark_cnt_q + {7'h00, mark};
    assign zrun_d = mark ? 7'h00 : zrun_q + 7'h01;
    assign win_ok_d = win_ok_q && above_p && (zrun_d < zero_limit);
    assign win_end = bit_tick && win_act_q && (win_cnt_q + 8'h01 == window_m);
    assign clear_hit = win_end && win_ok_d && (mark_cnt_d >= min_marks);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            win_act_q <= 1'b0;
            win_cnt_q <= 8'h00;
            mark_cnt_q <= 8'h00;
            zrun_q <= 7'h00;
            win_ok_q <= 1'b0;
        end else if (bit_tick) begin
            if (loss_q != in_loss || win_end) begin
                win_act_q <= 1'b0;
            end else if (!win_act_q) begin
                if (mark && above_p) begin
                    win_act_q <= 1'b1;
                    win_cnt_q <= 8'h01;
                    mark_cnt_q <= 8'h01;
                    zrun_q <= 7'h00;
                    win_ok_q <= 1'b1;
                end
            end else begin
                win_cnt_q <= win_cnt_q + 8'h01;
                mark_cnt_q <= mark_cnt_d;
                zrun_q <= zrun_d;
                win_ok_q <= win_ok_d;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            loss_q <= watch_loss;
        end else if (bit_tick) begin
            unique case (loss_q)
                watch_loss: if (declare_hit) begin
                    loss_q <= in_loss;
                end
                in_loss: if (clear_hit) begin
                    loss_q <= watch_loss;
                end
            endcase
        end
    end

    // loss indicator is independent of loopback selection
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            loss_indicator_pin <= 1'b0;
        end else if (clk_en) begin
            loss_indicator_pin <= loss_q == in_loss;
        end
    end

    // alarm detection over zero-counted blocks
    logic block_done;
    logic block_low;
    logic alarm_q;
    logic prev_low_q;
    logic prev_high_q;

    zero_block_counter u_blocks (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .clear(!cdr_en),
        .bit_tick(bit_tick),
        .bit_zero(!mark),
        .block_bits(t1_mode ? `T1_BLOCK_BITS : `E1_BLOCK_BITS),
        .min_zeros(t1_mode ? `T1_MIN_ZEROS : `E1_MIN_ZEROS),
        .block_done(block_done),
        .block_low(block_low)
    );

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_q <= 1'b0;
            prev_low_q <= 1'b0;
            prev_high_q <= 1'b0;
        end else if (clk_en) begin
            if (!cdr_en) begin
                alarm_q <= 1'b0;
                prev_low_q <= 1'b0;
                prev_high_q <= 1'b0;
            end else if (block_done) begin
                prev_low_q <= block_low;
                prev_high_q <= !block_low;
                if (t1_mode) begin
                    alarm_q <= block_low;
                end else if (block_low && prev_low_q) begin
                    alarm_q <= 1'b1;
                end else if (!block_low && (loss_criteria_select || prev_high_q)) begin
                    alarm_q <= 1'b0;
                end
            end
        end
    end

    // all ones generator on the master clock
    logic ones_phase_q;
    logic sys_insert;
    logic line_insert;

    assign sys_insert = loss_q == in_loss && sys_ais_en;
    assign line_insert = loss_q == in_loss && line_ais_en;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ones_phase_q <= 1'b0;
        end else if (mclk_tick) begin
            ones_phase_q <= !ones_phase_q;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            receive_data_positive_rail <= 1'b0;
            receive_data_negative_rail <= 1'b0;
            receive_clock_out <= 1'b0;
        end else if (clk_en) begin
            if (sys_insert) begin
                receive_data_positive_rail <= ones_phase_q;
                receive_data_negative_rail <= !ones_phase_q;
                receive_clock_out <= pin_lvl_q[MST_CLK];
            end else begin
                receive_data_positive_rail <= pin_lvl_q[pin_pos];
                receive_data_negative_rail <= pin_lvl_q[pin_neg];
                receive_clock_out <= pin_lvl_q[REC_CLK];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            transmit_line_positive <= 1'b0;
            transmit_line_negative <= 1'b0;
        end else if (clk_en) begin
            if (line_insert) begin
                transmit_line_positive <= ones_phase_q;
                transmit_line_negative <= !ones_phase_q;
            end else begin
                transmit_line_positive <= tx_system_positive;
                transmit_line_negative <= tx_system_negative;
            end
        end
    end

    // loss event flag, set wins
    logic event_q;
    logic loss_rise;
    logic acc_phase;
    logic acc_write;

    assign loss_rise = bit_tick && declare_hit;
    assign acc_phase = psel && penable;
    assign acc_write = acc_phase && pwrite && clk_en;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            event_q <= 1'b0;
        end else if (loss_rise) begin
            event_q <= 1'b1;
        end else if (acc_write && paddr == `EVENT_OFFSET && pwdata[`EVENT_LOSS_BIT]) begin
            event_q <= 1'b0;
        end
    end

    assign loss_irq = event_q && irq_en;

    // apb slave, no wait states
    logic [31:0] prdata_q;
    logic err_q;
    logic [31:0] status_word;

    assign status_word = {29'h0, loss_irq, alarm_q, loss_q == in_loss};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `CTRL_RESET;
        end else if (acc_write && paddr == `CTRL_OFFSET) begin
            ctrl_q <= pwdata[`CTRL_WIDTH-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else if (clk_en && psel && !penable) begin
            err_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            unique case (paddr)
                `CTRL_OFFSET: prdata_q <= {18'h0, ctrl_q};
                `STATUS_OFFSET: prdata_q <= status_word;
                `EVENT_OFFSET: prdata_q <= {31'h0, event_q};
                default: err_q <= 1'b1;
            endcase
        end
    end

    assign pready = acc_phase && clk_en;
    assign prdata = prdata_q;
    assign pslverr = pready && err_q;
endmodule
`default_nettype wire

// File: verification/loss_alarm_checker_sva.sv
`timescale 1ns/10ps
`default_nettype none
module loss_alarm_checker (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic receive_line_positive,
    input wire logic receive_line_negative,
    input wire logic below_declare_level,
    input wire logic above_clear_level,
    input wire logic receive_data_positive_rail,
    input wire logic receive_data_negative_rail,
    input wire logic transmit_line_positive,
    input wire logic transmit_line_negative,
    input wire logic loss_indicator_pin,
    input wire logic loss_irq,
    input wire logic [9:0] declare_threshold,
    input wire logic [9:0] clear_threshold,
    input wire logic threshold_in_db
);
    logic [7:0] quiet_q;
    logic [7:0] lively_q;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b || !below_declare_level || receive_line_positive || receive_line_negative) begin
            quiet_q <= 8'h00;
        end else if (quiet_q != 8'hff) begin
            quiet_q <= quiet_q + 8'h01;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b || !above_clear_level) begin
            lively_q <= 8'h00;
        end else if (lively_q != 8'hff) begin
            lively_q <= lively_q + 8'h01;
        end
    end
    property p_ready_now;
        pready == (psel && penable && clk_en);
    endproperty
    a_ready_now: assert property (p_ready_now) else $error("pready wrong");
    property p_err_read_zero;
        pslverr |-> pready && (pwrite || prdata == 32'h0);
    endproperty
    a_err_read_zero: assert property (p_err_read_zero) else $error("bad error");
    property p_short_level;
        !threshold_in_db && declare_threshold != 10'h0 |-> declare_threshold == 10'd800 && clear_threshold == 10'd1000;
    endproperty
    a_short_level: assert property (p_short_level) else $error("short levels");
    property p_long_level;
        threshold_in_db |-> declare_threshold - clear_threshold == 10'd4 && declare_threshold <= 10'd48;
    endproperty
    a_long_level: assert property (p_long_level) else $error("long levels");
    property p_declare_quiet;
        $rose(loss_indicator_pin) |-> quiet_q >= 8'd64;
    endproperty
    a_declare_quiet: assert property (p_declare_quiet) else $error("early declare");
    property p_clear_lively;
        $fell(loss_indicator_pin) |-> lively_q >= 8'd64;
    endproperty
    a_clear_lively: assert property (p_clear_lively) else $error("early clear");
    property p_hold_loss;
        (below_declare_level && !above_clear_level) [*8] ##0 loss_indicator_pin |=> loss_indicator_pin;
    endproperty
    a_hold_loss: assert property (p_hold_loss) else $error("loss dropped");
    property p_irq_follows;
        $rose(loss_irq) && !$past(pwrite && penable) |-> ##[0:2] loss_indicator_pin;
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("stray irq");
    property p_rails_apart;
        !(receive_data_positive_rail && receive_data_negative_rail) && !(transmit_line_positive && transmit_line_negative);
    endproperty
    a_rails_apart: assert property (p_rails_apart) else $error("both rails high");
    c_declare: cover property ($rose(loss_indicator_pin));
    c_clear: cover property ($fell(loss_indicator_pin));
    c_refused: cover property (pslverr);
endmodule
bind line_loss_and_alarm_detector loss_alarm_checker chk (.*);
`default_nettype wire

// File: verification/line_front_model.sv
`timescale 1ns/10ps
`default_nettype none
module line_front_model #(
    parameter int BIT_HALF = 4,
    parameter int MCLK_HALF = 3
) (
    input wire logic sys_clk,
    input wire logic [1:0] mode,
    output logic receive_line_positive = 1'b0,
    output logic receive_line_negative = 1'b0,
    output logic below_declare_level = 1'b0,
    output logic above_clear_level = 1'b1,
    output logic recovered_clock_pin = 1'b0,
    output logic master_clock_pin = 1'b0,
    output logic tx_system_positive = 1'b0,
    output logic tx_system_negative = 1'b0
);
    int div_q = 0;
    int mdiv_q = 0;
    int idx_q = 0;
    int idx;
    logic [1:0] mode_q = 2'h1;
    logic pol_q = 1'b0;
    logic mark;
    always @(posedge sys_clk) begin
        mdiv_q <= (mdiv_q == MCLK_HALF - 1) ? 0 : mdiv_q + 1;
        if (mdiv_q == MCLK_HALF - 1) begin
            master_clock_pin <= ~master_clock_pin;
        end
        div_q <= (div_q == BIT_HALF - 1) ? 0 : div_q + 1;
        if (div_q == BIT_HALF - 1) begin
            recovered_clock_pin <= ~recovered_clock_pin;
        end
        // symbol launched on the falling half, settled at the rising one
        if (div_q == BIT_HALF - 1 && recovered_clock_pin) begin
            idx = (mode == mode_q) ? idx_q + 1 : 0;
            mark = (mode == 2'h1) || (mode == 2'h2 && idx % 4 != 3);
            idx_q <= idx;
            mode_q <= mode;
            pol_q <= pol_q ^ mark;
            receive_line_positive <= mark && !pol_q;
            receive_line_negative <= mark && pol_q;
            tx_system_positive <= mark && pol_q;
            tx_system_negative <= mark && !pol_q;
            below_declare_level <= (mode == 2'h0);
            above_clear_level <= (mode != 2'h0);
        end
    end
endmodule
`default_nettype wire

// File: verification/tb_line_loss_and_alarm_detector.sv
`timescale 1ns/10ps
`default_nettype none
module tb_line_loss_and_alarm_detector;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] mode = 2'h1;
    logic [31:0] prdata;
    logic [9:0] declare_threshold, clear_threshold;
    logic pready, pslverr, receive_line_positive, receive_line_negative, below_declare_level, above_clear_level;
    logic recovered_clock_pin, master_clock_pin, tx_system_positive, tx_system_negative, receive_clock_out;
    logic receive_data_positive_rail, receive_data_negative_rail, transmit_line_positive, transmit_line_negative;
    logic loss_indicator_pin, loss_irq, threshold_in_db;
    int bad_count = 0;
    int n_compared = 0;
    always #5 sys_clk = ~sys_clk;
    line_front_model far_end (.*);
    line_loss_and_alarm_detector dut (.*);
    task automatic final_report;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd,
        output logic err);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            bad_count++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(a, 1'b1, d, rd, err);
    endtask
    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic err;
        apb(a, 1'b0, 32'h0, rd, err);
        check(rd, exp);
        check(err, exp_err);
    endtask
    task automatic set_mode(input logic [1:0] m);
        @(posedge recovered_clock_pin);
        @(posedge sys_clk);
        mode <= m;
    endtask
    task automatic count_until(input logic lvl, output int n);
        n = 0;
        while (loss_indicator_pin !== lvl && n < 2200) begin
            @(posedge recovered_clock_pin);
            n++;
        end
        if (n >= 2200) begin
            bad_count++;
            final_report();
        end
    endtask
    initial begin
        logic [31:0] c;
        int n;
        int codes[6] = '{0, 1, 17, 21, 22, 31};
        int db[6] = '{4, 6, 38, 46, 48, 48};
        int nn[4] = '{32, 2048, 175, 1544};
        int mm[4] = '{32, 32, 128, 128};
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge sys_clk);
        reg_read(8'h00, 32'h4a8, 1'b0);
        reg_read(8'h0c, 32'h0, 1'b1);
        check(declare_threshold, 32'd800);
        check(clear_threshold, 32'd1000);
        for (int i = 0; i < 6; i++) begin
            reg_write(8'h00, 32'h404 | (32'(codes[i]) << 3));
            repeat (2) @(posedge sys_clk);
            check(declare_threshold, db[i]);
            check(clear_threshold, db[i] - 4);
        end
        for (int i = 0; i < 4; i++) begin
            c = 32'h4a8 | 32'(i >> 1) | 32'((i & 1) << 1) | 32'(i << 12) | 32'((i & 1) * 32'h300);
            reg_write(8'h00, c | (i > 0 ? 32'h800 : 32'h0));
            set_mode(2'h0);
            count_until(1'b1, n);
            check(n, nn[i] + 1);
            check(loss_irq, 32'(i > 0));
            repeat (6) @(posedge sys_clk);
            check(receive_data_positive_rail ^ receive_data_negative_rail, i & 1);
            check(transmit_line_positive ^ transmit_line_negative, i & 1);
            reg_read(8'h08, 32'h1, 1'b0);
            reg_write(8'h08, 32'h1);
            reg_read(8'h08, 32'h0, 1'b0);
            check(loss_irq, 32'h0);
            set_mode(2'h2);
            count_until(1'b0, n);
            check(n, mm[i] + 1);
        end
        for (int i = 0; i < 2; i++) begin
            reg_write(8'h00, 32'h0a8 | 32'(i << 1));
            reg_read(8'h04, 32'h0, 1'b0);
            set_mode(2'h1);
            reg_write(8'h00, 32'h4a8 | 32'(i << 1));
            repeat (768) @(posedge recovered_clock_pin);
            reg_read(8'h04, 32'h0, 1'b0);
            repeat (400) @(posedge recovered_clock_pin);
            reg_read(8'h04, 32'h2, 1'b0);
            set_mode(2'h2);
            repeat (400) @(posedge recovered_clock_pin);
            reg_read(8'h04, 32'(i == 0) << 1, 1'b0);
            repeat (500) @(posedge recovered_clock_pin);
            reg_read(8'h04, 32'h0, 1'b0);
        end
        final_report();
    end
endmodule
`default_nettype wire
